// *** src/aohc_ctrl.sv ***
// Configuration register, auto-increment sequencing and hibernate control.
`timescale 1ns/1ps
module aohc_ctrl #(
	parameter int BOOT_CYCLES = 16
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWriteData,
	output logic [7:0] regReadData,
	input wire logic [7:0] autoincAddr,
	output logic [7:0] autoincNextAddr,
	input wire logic sampleValid,
	input wire logic [11:0] xSample,
	input wire logic [11:0] ySample,
	input wire logic [11:0] zSample,
	output logic [11:0] magnitude,
	output logic magnitudeValid,
	input wire logic [1:0] changeDetectionMode,
	output logic [11:0] changeDetectionInput,
	input wire logic boot_mode_strap,
	input wire logic wakePin,
	input wire logic motion_detect_pin,
	output logic hibernating,
	output logic booting,
	output logic volatileClear
);
	initial begin
		if (BOOT_CYCLES < 1) $error("aohc_ctrl: BOOT_CYCLES must be at least 1");
		if (BOOT_CYCLES > 65536) $error("aohc_ctrl: BOOT_CYCLES does not fit the boot counter");
	end

	aohc_pkg::aohc_config_s cfg_reg, cfg_next;
	aohc_pkg::aohc_state_e state_reg, state_next;
	logic [7:0] readData_reg, readData_next;
	logic [7:0] nextAddr_reg, nextAddr_next;
	logic [11:0] cdInput_reg, cdInput_next;
	logic wakeLevel_reg, wakeLevel_next;
	logic clear_reg, clear_next;
	logic [15:0] bootCount_reg, bootCount_next;
	logic [11:0] magValue;
	logic magValid_reg;
	logic hib_reg, hib_next;
	logic boot_reg, boot_next;

	function automatic logic [7:0] packCfg(input aohc_pkg::aohc_config_s c);
		packCfg = {3'h0, c.magnitudeEnable, c.xAutoincSkip, c.yAutoincSkip,
			c.zAutoincSkip, c.hibernate};
	endfunction

	// Walks the axis pair addresses, skipping disabled groups.
	function automatic logic [7:0] stepAddr(input logic [7:0] a,
			input aohc_pkg::aohc_config_s c);
		logic [7:0] n;
		n = 8'(a + 8'h01);
		if (n == aohc_pkg::X_LOW_ADDR && c.xAutoincSkip) n = aohc_pkg::Y_LOW_ADDR;
		if (n == aohc_pkg::Y_LOW_ADDR && c.yAutoincSkip) n = aohc_pkg::Z_LOW_ADDR;
		if (n == aohc_pkg::Z_LOW_ADDR && c.zAutoincSkip) n = aohc_pkg::MAG_LOW_ADDR;
		if (n == aohc_pkg::MAG_LOW_ADDR && !c.magnitudeEnable) begin
			n = aohc_pkg::AFTER_LAST_ADDR;
		end
		stepAddr = n;
	endfunction

	aohc_magnitude #(
		.W(aohc_pkg::MAG_WIDTH)
	) u_magnitude (
		.clock(clock),
		.reset_n(reset_n),
		.sampleValid(sampleValid),
		.enable(cfg_reg.magnitudeEnable && state_reg == aohc_pkg::AOHC_RUN),
		.xSample(xSample),
		.ySample(ySample),
		.zSample(zSample),
		.magnitude(magValue),
		.magnitudeValid(magValid_reg)
	);

	always_comb begin
		cfg_next = cfg_reg;
		state_next = state_reg;
		readData_next = readData_reg;
		wakeLevel_next = wakeLevel_reg;
		clear_next = 1'b0;
		bootCount_next = bootCount_reg;
		nextAddr_next = stepAddr(autoincAddr, cfg_reg);
		cdInput_next = cdInput_reg;
		if (magValid_reg && changeDetectionMode == aohc_pkg::CHANGE_MODE_MAGNITUDE) begin
			cdInput_next = magValue;
		end
		unique case (state_reg)
			aohc_pkg::AOHC_RUN: begin
				// Power modes stay with the wake and sleep fields while the bit is low.
				if (regRead && regAddr == aohc_pkg::CONFIG_OFFSET) begin
					readData_next = packCfg(cfg_reg);
				end
				if (regWrite && regAddr == aohc_pkg::CONFIG_OFFSET) begin
					cfg_next = aohc_pkg::aohc_config_s'(regWriteData[4:0]
						& aohc_pkg::CONFIG_WRITE_MASK[4:0]);
					if (regWriteData[aohc_pkg::HIBERNATE_BIT] && !boot_mode_strap) begin
						state_next = aohc_pkg::AOHC_HIBERNATE;
						wakeLevel_next = wakePin;
					end
				end
				if (boot_mode_strap && !motion_detect_pin) begin
					state_next = aohc_pkg::AOHC_HIBERNATE;
				end
				if (state_next == aohc_pkg::AOHC_HIBERNATE) begin
					clear_next = 1'b1;
					cfg_next = aohc_pkg::aohc_config_s'(aohc_pkg::CONFIG_RESET[4:0]);
					readData_next = 8'h00;
					cdInput_next = 12'h000;
				end
			end
			aohc_pkg::AOHC_HIBERNATE: begin
				// Register accesses are lost while shut down.
				if ((!boot_mode_strap && wakePin != wakeLevel_reg)
						|| (boot_mode_strap && motion_detect_pin)) begin
					state_next = aohc_pkg::AOHC_BOOT;
					bootCount_next = 16'(BOOT_CYCLES - 1);
				end
			end
			aohc_pkg::AOHC_BOOT: begin
				// The host holds off while this runs; and
				if (bootCount_reg == 16'h0000) begin
					state_next = aohc_pkg::AOHC_RUN;
				end else begin
					bootCount_next = 16'(bootCount_reg - 16'h0001);
				end
			end
			default: begin
				state_next = aohc_pkg::AOHC_RUN;
			end
		endcase
		// Status follows the state being entered, so it lines up with the state register.
		hib_next = (state_next == aohc_pkg::AOHC_HIBERNATE);
		boot_next = (state_next == aohc_pkg::AOHC_BOOT);
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			cfg_reg <= aohc_pkg::aohc_config_s'(aohc_pkg::CONFIG_RESET[4:0]);
			state_reg <= aohc_pkg::AOHC_RUN;
			readData_reg <= 8'h00;
			nextAddr_reg <= 8'h00;
			cdInput_reg <= 12'h000;
			wakeLevel_reg <= 1'b0;
			clear_reg <= 1'b0;
			bootCount_reg <= 16'h0000;
			hib_reg <= 1'b0;
			boot_reg <= 1'b0;
		end else begin
			cfg_reg <= cfg_next;
			state_reg <= state_next;
			readData_reg <= readData_next;
			nextAddr_reg <= nextAddr_next;
			cdInput_reg <= cdInput_next;
			wakeLevel_reg <= wakeLevel_next;
			clear_reg <= clear_next;
			bootCount_reg <= bootCount_next;
			hib_reg <= hib_next;
			boot_reg <= boot_next;
		end
	end

	assign regReadData = readData_reg;
	assign autoincNextAddr = nextAddr_reg;
	assign magnitude = magValue;
	assign magnitudeValid = magValid_reg;
	assign changeDetectionInput = cdInput_reg;
	assign hibernating = hib_reg;
	assign booting = boot_reg;
	assign volatileClear = clear_reg;
endmodule

// *** src/aohc_pkg.sv ***
// Package with constants and types of the output select and hibernate control block.
// Overview of operation
// - Magnitude enable computes 12-bit magnitude on each valid sample.
// - Magnitude registers in auto-increment only when enabled.
// - Change-detection mode 1 takes magnitude as input.
// - Bit 3 set skips X in auto-increment.
// - Bit 2 set skips Y in auto-increment.
// - Bit 1 set skips Z in auto-increment.
// - Hibernate bit low keeps selected power mode.
// - Grounded strap: writing hibernate one clears configuration, read data and change input.
// - Grounded strap: wake pin edge ends hibernate.
// - High strap: motion pin high starts active operation.
// - High strap: motion pin low enters hibernate.
package aohc_pkg;
	localparam logic [7:0] CONFIG_OFFSET = 8'h19;
	localparam logic [7:0] CONFIG_RESET = 8'h00;
	localparam logic [7:0] CONFIG_WRITE_MASK = 8'h1F;
	localparam int MAG_EN_BIT = 4;
	localparam int X_SKIP_BIT = 3;
	localparam int Y_SKIP_BIT = 2;
	localparam int Z_SKIP_BIT = 1;
	localparam int HIBERNATE_BIT = 0;
	localparam int MAG_WIDTH = 12;
	localparam logic [7:0] X_LOW_ADDR = 8'h04;
	localparam logic [7:0] Y_LOW_ADDR = 8'h06;
	localparam logic [7:0] Z_LOW_ADDR = 8'h08;
	localparam logic [7:0] MAG_LOW_ADDR = 8'h0A;
	localparam logic [7:0] AFTER_LAST_ADDR = 8'h0C;
	localparam logic [1:0] CHANGE_MODE_MAGNITUDE = 2'h1;

	typedef enum logic [1:0] {
		AOHC_RUN,
		AOHC_HIBERNATE,
		AOHC_BOOT
	} aohc_state_e;

	typedef struct packed {
		logic magnitudeEnable;
		logic xAutoincSkip;
		logic yAutoincSkip;
		logic zAutoincSkip;
		logic hibernate;
	} aohc_config_s;
endpackage

// *** src/aohc_magnitude.sv ***
// Vector magnitude approximation of three signed axis samples.
`timescale 1ns/1ps
module aohc_magnitude #(
	parameter int W = 12
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic sampleValid,
	input wire logic enable,
	input wire logic [W-1:0] xSample,
	input wire logic [W-1:0] ySample,
	input wire logic [W-1:0] zSample,
	output logic [W-1:0] magnitude,
	output logic magnitudeValid
);
	initial begin
		if (W < 4) $error("aohc_magnitude: width too small");
	end
	logic [W-1:0] magnitude_reg, magnitude_next;
	logic valid_reg, valid_next;

	function automatic logic [W-1:0] absVal(input logic [W-1:0] v);
		absVal = v[W-1] ? W'(-v) : v;
	endfunction

	// An alpha-max-beta-min form avoids a square root at the cost of up to about 22 percent overestimate.
	always_comb begin
		logic [W+1:0] a, b, c, big, sum;
		a = {2'h0, absVal(xSample)};
		b = {2'h0, absVal(ySample)};
		c = {2'h0, absVal(zSample)};
		big = (a > b) ? ((a > c) ? a : c) : ((b > c) ? b : c);
		sum = big + ((a + b + c - big) >> 1);
		magnitude_next = magnitude_reg;
		valid_next = 1'b0;
		if (sampleValid && enable) begin
			magnitude_next = (sum[W+1:W] != 2'h0) ? {W{1'b1}} : sum[W-1:0];
			valid_next = 1'b1;
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			magnitude_reg <= '0;
			valid_reg <= 1'b0;
		end else begin
			magnitude_reg <= magnitude_next;
			valid_reg <= valid_next;
		end
	end
	assign magnitude = magnitude_reg;
	assign magnitudeValid = valid_reg;
endmodule

// *** tb/aohc_ctrl_properties.sv ***
// Checker of the configuration and hibernate control ports.
`timescale 1ns/1ps
module aohc_ctrl_properties (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic regWrite,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWriteData,
	input wire logic [7:0] autoincAddr,
	input wire logic [7:0] autoincNextAddr,
	input wire logic sampleValid,
	input wire logic [11:0] magnitude,
	input wire logic magnitudeValid,
	input wire logic [1:0] changeDetectionMode,
	input wire logic [11:0] changeDetectionInput,
	input wire logic boot_mode_strap,
	input wire logic wakePin,
	input wire logic motion_detect_pin,
	input wire logic hibernating,
	input wire logic booting,
	input wire logic volatileClear
);
	default clocking @(posedge clock); endclocking
	default disable iff (!reset_n);
	logic run;
	logic wrOk;
	logic [4:0] cfg;
	assign run = !hibernating && !booting;
	assign wrOk = regWrite && regAddr == 8'h19 && run;
	// Shadow of the register; it is wiped at the same edge as the design's own copy.
	always_ff @(posedge clock or negedge reset_n)
		if (!reset_n) cfg <= 5'h00;
		else if (run && boot_mode_strap && !motion_detect_pin) cfg <= 5'h00;
		else if (wrOk && regWriteData[0] && !boot_mode_strap) cfg <= 5'h00;
		else if (wrOk) cfg <= regWriteData[4:0];
	sequence s_hib;
		wrOk && regWriteData[0] && !boot_mode_strap;
	endsequence
	a_hib_entry: assert property (s_hib |=> hibernating && volatileClear)
		else $error("hibernate not entered");
	a_wake_edge: assert property ($rose(booting) && !boot_mode_strap
		|-> $past(wakePin) != $past(wakePin, 2)) else $error("boot without wake edge");
	a_motion_low: assert property (boot_mode_strap && !motion_detect_pin && run
		|=> hibernating) else $error("motion low ignored");
	a_motion_high: assert property (boot_mode_strap && motion_detect_pin && hibernating
		&& !booting |-> ##[1:2] booting) else $error("motion high ignored");
	a_mag_follow: assert property (sampleValid && run
		|=> magnitudeValid == $past(cfg[4])) else $error("magnitude enable ignored");
	a_change_route: assert property (magnitudeValid && changeDetectionMode == 2'h1
		|=> changeDetectionInput == $past(magnitude)) else $error("change input wrong");
	a_skip_x: assert property (autoincAddr == 8'h03 && cfg[3] && !cfg[2]
		|=> autoincNextAddr == 8'h06) else $error("x skip");
	a_skip_y: assert property (autoincAddr == 8'h05 && cfg[2] && !cfg[1]
		|=> autoincNextAddr == 8'h08) else $error("y skip");
	a_skip_z: assert property (autoincAddr == 8'h07 && cfg[1] && cfg[4]
		|=> autoincNextAddr == 8'h0A) else $error("z skip");
	a_skip_mag: assert property (autoincAddr == 8'h09 && !cfg[4]
		|=> autoincNextAddr == 8'h0C) else $error("magnitude skip");
endmodule
bind aohc_ctrl aohc_ctrl_properties i_aohc_ctrl_properties (.clock, .reset_n, .regWrite,
	.regAddr, .regWriteData, .autoincAddr, .autoincNextAddr, .sampleValid, .magnitude,
	.magnitudeValid, .changeDetectionMode, .changeDetectionInput, .boot_mode_strap,
	.wakePin, .motion_detect_pin, .hibernating, .booting, .volatileClear);

// *** tb/aohc_host_model.sv ***
// Host model that reaches the configuration register and drives the wake pin.
`timescale 1ns/1ps
module aohc_host_model #(
	parameter int BOOT = 2
) (
	input wire logic clock,
	input wire logic [7:0] regReadData,
	output logic regWrite,
	output logic regRead,
	output logic [7:0] regAddr,
	output logic [7:0] regWriteData,
	output logic wakePin
);
	initial {regWrite, regRead, regAddr, regWriteData, wakePin} = {2'b00, 16'hA55A, 1'b0};
	task automatic access(input logic wr, input logic [7:0] a, d, output logic [7:0] q);
		@(negedge clock);
		{regWrite, regRead, regAddr, regWriteData} = {wr, !wr, a, d};
		@(negedge clock);
		q = regReadData;
		// Released lines flip so that a stale address never looks like a held one.
		{regWrite, regRead, regAddr, regWriteData} = {2'b00, ~a, ~d};
	endtask
	task automatic wake();
		@(negedge clock);
		wakePin = !wakePin;
		repeat (BOOT + 4) @(negedge clock);
	endtask
endmodule

// *** tb/aohc_ctrl_bench.sv ***
// Self-checking bench of the configuration and hibernate control block.
`timescale 1ns/1ps
module aohc_ctrl_bench;
	logic clock = 1'b0, reset_n = 1'b0, sampleValid = 1'b0, boot_mode_strap = 1'b0;
	logic motion_detect_pin = 1'b1;
	logic regWrite, regRead, wakePin, magnitudeValid, hibernating, booting, volatileClear;
	logic [7:0] regAddr, regWriteData, regReadData, autoincNextAddr, q;
	logic [7:0] autoincAddr = 8'h00;
	logic [11:0] xSample = 12'h100, ySample = 12'h080, zSample = 12'h040;
	logic [11:0] magnitude, changeDetectionInput;
	logic [1:0] changeDetectionMode = 2'h1;
	int mismatches = 0, n_compared = 0, cycles = 0;
	always #2 clock = !clock;
	aohc_ctrl #(.BOOT_CYCLES(2)) i_aohc_ctrl (.clock, .reset_n, .regWrite, .regRead, .regAddr,
		.regWriteData, .regReadData, .autoincAddr, .autoincNextAddr, .sampleValid, .xSample,
		.ySample, .zSample, .magnitude, .magnitudeValid, .changeDetectionMode,
		.changeDetectionInput, .boot_mode_strap, .wakePin, .motion_detect_pin, .hibernating,
		.booting, .volatileClear);
	aohc_host_model #(.BOOT(2)) i_aohc_host_model (.clock, .regReadData, .regWrite, .regRead,
		.regAddr, .regWriteData, .wakePin);
	task automatic chk(input logic [11:0] seen, exp);
		n_compared++;
		if (seen !== exp) begin
			mismatches++;
			$display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic t_register();
		i_aohc_host_model.access(1'b0, 8'h19, 8'h00, q);
		chk(q, 8'h00);
		i_aohc_host_model.access(1'b1, 8'h19, 8'hFE, q);
		i_aohc_host_model.access(1'b0, 8'h19, 8'h00, q);
		chk(q, 8'h1E);
		chk(hibernating, 1'b0);
	endtask
	task automatic t_autoinc();
		logic [7:0] cfgs [5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h12};
		logic [7:0] c, e;
		for (int i = 0; i < 5; i++) begin
			c = cfgs[i];
			i_aohc_host_model.access(1'b1, 8'h19, c, q);
			for (logic [7:0] a = 8'h03; a < 8'h0A; a += 8'h02) begin
				@(negedge clock) autoincAddr = a;
				e = a + 8'h01;
				if ((e == 8'h04 && c[3]) || (e == 8'h06 && c[2]) || (e == 8'h08 && c[1])
					|| (e == 8'h0A && !c[4])) e = e + 8'h02;
				@(negedge clock) chk(autoincNextAddr, e);
			end
		end
		autoincAddr = 8'h00;
	endtask
	task automatic t_magnitude();
		logic [11:0] m;
		m = xSample + ((ySample + zSample) >> 1);
		for (int en = 1; en >= 0; en--) begin
			i_aohc_host_model.access(1'b1, 8'h19, en ? 8'h10 : 8'h00, q);
			@(negedge clock) sampleValid = 1'b1;
			@(negedge clock) sampleValid = 1'b0;
			chk(magnitudeValid, en[0]);
			if (en) chk(magnitude, m);
			@(negedge clock) if (en) chk(changeDetectionInput, m);
		end
		// A negative sample with the mode off: the result moves, the change input must not.
		changeDetectionMode = 2'h0;
		i_aohc_host_model.access(1'b1, 8'h19, 8'h10, q);
		@(negedge clock) {sampleValid, xSample} = {1'b1, 12'hE00};
		@(negedge clock) sampleValid = 1'b0;
		chk(magnitude, 12'h260);
		@(negedge clock) chk(changeDetectionInput, m);
		{changeDetectionMode, xSample} = {2'h1, 12'h100};
	endtask
	task automatic t_hib_wake();
		i_aohc_host_model.access(1'b1, 8'h19, 8'h11, q);
		chk(hibernating, 1'b1);
		chk(volatileClear, 1'b1);
		i_aohc_host_model.access(1'b1, 8'h19, 8'h1E, q);
		chk(hibernating, 1'b1);
		i_aohc_host_model.wake();
		chk(hibernating | booting, 1'b0);
		i_aohc_host_model.access(1'b0, 8'h19, 8'h00, q);
		chk(q, 8'h00);
		// The pin now rests high, so the second wake is a falling edge.
		i_aohc_host_model.access(1'b1, 8'h19, 8'h01, q);
		chk(hibernating, 1'b1);
		i_aohc_host_model.wake();
		chk(hibernating | booting, 1'b0);
	endtask
	task automatic t_hib_strap();
		boot_mode_strap = 1'b1;
		motion_detect_pin = 1'b0;
		@(negedge clock) chk(hibernating, 1'b1);
		motion_detect_pin = 1'b1;
		repeat (6) @(negedge clock);
		chk(hibernating | booting, 1'b0);
		boot_mode_strap = 1'b0;
	endtask
	task automatic t_reset();
		i_aohc_host_model.access(1'b1, 8'h19, 8'h1E, q);
		reset_n = 1'b0;
		repeat (2) @(negedge clock);
		reset_n = 1'b1;
		chk(hibernating | booting | volatileClear | magnitudeValid, 1'b0);
		i_aohc_host_model.access(1'b0, 8'h19, 8'h00, q);
		chk(q, 8'h00);
	endtask
	initial begin
		repeat (6) @(negedge clock);
		reset_n = 1'b1;
		t_register();
		t_autoinc();
		t_magnitude();
		t_hib_wake();
		t_hib_strap();
		t_reset();
		end_sim();
	end
	always @(posedge clock) begin
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			end_sim();
		end
	end
endmodule
